/* File: verilog/cpu_core.sv */
// fetch sequencing, pc and stack, data addressing, accumulator and status
// assumes rom and data arrays answer combinationally to the address ports
// and that the decoded control inputs are held for the whole cycle
`include "core_defs.svh"
module cpu_core
    import core_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [13:0] rom_data,
    input wire logic [7:0] ram_rdata,
    input wire logic irq_take,
    input wire flow_t flow,
    input wire logic skip_cond,
    input wire alu_op_t alu_op,
    input wire logic use_literal,
    input wire logic [6:0] file_addr,
    input wire logic [2:0] bit_sel,
    input wire logic dest_file,
    input wire logic dest_acc,
    input wire logic flags_cz,
    input wire logic flags_z,
    input wire logic flags_c,
    input wire logic load_literal_acc,
    output logic [10:0] rom_addr,
    output logic [13:0] instr,
    output logic instr_valid,
    output logic [7:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic ram_we,
    output logic [7:0] acc_out,
    output logic [7:0] status_out,
    output logic [7:0] pointer_out,
    output logic phase_two,
    output logic bit_ok
);
    // ----------------------------------------
    // phase divider
    // ----------------------------------------
    logic phase_r;
    logic phase_nxt;
    logic phase_one;
    always_comb
    begin
        phase_nxt = ~phase_r;
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            phase_r <= 1'b0;
        else
            phase_r <= phase_nxt;
    end
    assign phase_one = ~phase_r;

    // ----------------------------------------
    // data addressing and alu
    // ----------------------------------------
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] pointer_r;
    logic [7:0] pointer_nxt;
    logic [6:0] eff_addr;
    logic bank;
    logic via_port;
    logic [7:0] file_val;
    logic [7:0] operand;
    logic [7:0] result;
    logic carry_out;
    logic nib_out;
    logic zero_out;
    logic [10:0] pc_r;

    always_comb
    begin
        via_port = (file_addr == `ADDR_INDIRECT);
        eff_addr = via_port ? pointer_r[6:0] : file_addr;
        bank = via_port ? pointer_r[7] : status_r[`ST_BANK];
        if (via_port && pointer_r[6:0] == `ADDR_INDIRECT)
            file_val = 8'h00;
        else if (eff_addr == `ADDR_STATUS)
            file_val = status_r;
        else if (eff_addr == `ADDR_POINTER)
            file_val = pointer_r;
        else if (eff_addr == `ADDR_PCL)
            file_val = pc_r[7:0];
        else
            file_val = ram_rdata;
        operand = use_literal ? instr[7:0] : file_val;
    end

    core_alu u_alu
    (
        .op(alu_op),
        .acc(acc_r),
        .opnd(operand),
        .bit_sel(bit_sel),
        .carry_in(status_r[`ST_C]),
        .result(result),
        .carry_out(carry_out),
        .nib_out(nib_out),
        .zero_out(zero_out)
    );

    // ----------------------------------------
    // execute: registers commit at the end of phase two, data array writes at the end of the next phase one
    // ----------------------------------------
    logic exec;
    logic file_we;
    logic [7:0] ram_addr_nxt;
    logic [7:0] ram_addr_r;
    logic [7:0] ram_wdata_r;
    logic ram_we_r;
    logic bit_ok_r;
    logic bit_ok_nxt;
    logic instr_valid_r;
    logic pcl_write;

    always_comb
    begin
        exec = phase_r && instr_valid_r;
        // the pointer pointing at the port itself swallows the write
        file_we = exec && dest_file && !(via_port && pointer_r[6:0] == `ADDR_INDIRECT);
        // shared registers sit in bank zero whatever the bank bit says
        ram_addr_nxt = {(eff_addr <= `SFR_TOP) ? 1'b0 : bank, eff_addr};
        bit_ok_nxt = (eff_addr <= `BIT_TOP);
        pcl_write = file_we && eff_addr == `ADDR_PCL;
        acc_nxt = acc_r;
        status_nxt = status_r;
        pointer_nxt = pointer_r;
        if (exec)
        begin
            if (dest_acc)
                acc_nxt = load_literal_acc ? instr[7:0] : result;
            if (file_we && eff_addr == `ADDR_STATUS)
                status_nxt = (status_r & ~`STATUS_WMASK) | (result & `STATUS_WMASK);
            if (file_we && eff_addr == `ADDR_POINTER)
                pointer_nxt = result;
            if (flags_z)
                status_nxt[`ST_Z] = zero_out;
            if (flags_cz)
            begin
                status_nxt[`ST_C] = carry_out;
                status_nxt[`ST_NIB] = nib_out;
            end
            if (flags_c)
                status_nxt[`ST_C] = carry_out;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            acc_r <= 8'h00;
            status_r <= `STATUS_RESET;
            pointer_r <= 8'h00;
            ram_addr_r <= 8'h00;
            ram_wdata_r <= 8'h00;
            ram_we_r <= 1'b0;
            bit_ok_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            status_r <= status_nxt;
            pointer_r <= pointer_nxt;
            ram_addr_r <= ram_addr_nxt;
            ram_wdata_r <= result;
            ram_we_r <= file_we && eff_addr > `SFR_TOP;
            bit_ok_r <= bit_ok_nxt;
        end
    end

    // ----------------------------------------
    // program counter, fetch and flush
    // ----------------------------------------
    logic [10:0] pc_nxt;
    logic [13:0] instr_r;
    logic [13:0] instr_nxt;
    logic instr_valid_nxt;
    logic flush_r;
    logic flush_nxt;
    logic push;
    logic pop;
    logic [10:0] stack_top;
    logic [10:0] fetch_r;
    logic [10:0] fetch_nxt;

    always_comb
    begin
        pc_nxt = pc_r;
        fetch_nxt = fetch_r;
        instr_nxt = instr_r;
        instr_valid_nxt = instr_valid_r;
        flush_nxt = flush_r;
        push = 1'b0;
        pop = 1'b0;
        if (phase_one)
        begin
            fetch_nxt = pc_r;
            pc_nxt = pc_r + 11'h001;
        end
        else
        begin
            instr_nxt = rom_data;
            flush_nxt = 1'b0;
            if (irq_take)
            begin
                push = 1'b1;
                pc_nxt = `IRQ_VECTOR;
                flush_nxt = 1'b1;
            end
            else if (exec)
            begin
                unique case (flow)
                    FLOW_JUMP, FLOW_CALL:
                    begin
                        push = (flow == FLOW_CALL);
                        pc_nxt = instr_r[10:0];
                        flush_nxt = 1'b1;
                    end
                    FLOW_RET:
                    begin
                        pop = 1'b1;
                        pc_nxt = stack_top;
                        flush_nxt = 1'b1;
                    end
                    FLOW_SKIP: flush_nxt = skip_cond;
                    FLOW_NEXT:
                    begin
                        if (pcl_write)
                        begin
                            pc_nxt = {pc_r[10:8], result};
                            flush_nxt = 1'b1;
                        end
                    end
                endcase
            end
            // the word latched on this edge is the stale prefetch, so it is squashed here
            instr_valid_nxt = !flush_nxt;
        end
    end

    return_stack u_stack
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .push(push),
        .pop(pop),
        .push_addr(fetch_r),
        .top_addr(stack_top)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pc_r <= `RESET_VECTOR;
            fetch_r <= `RESET_VECTOR;
            instr_r <= 14'h0000;
            instr_valid_r <= 1'b0;
            flush_r <= 1'b0;
        end
        else
        begin
            pc_r <= pc_nxt;
            fetch_r <= fetch_nxt;
            instr_r <= instr_nxt;
            instr_valid_r <= instr_valid_nxt;
            flush_r <= flush_nxt;
        end
    end

    assign instr = instr_r;
    assign rom_addr = fetch_r;
    assign instr_valid = instr_valid_r;
    assign ram_addr = ram_addr_r;
    assign ram_wdata = ram_wdata_r;
    assign ram_we = ram_we_r;
    assign acc_out = acc_r;
    assign status_out = status_r;
    assign pointer_out = pointer_r;
    assign phase_two = phase_r;
    assign bit_ok = bit_ok_r;
endmodule

/* File: verilog/core_defs.svh */
// constants for the fetch, addressing and status core
// assumes a single 100 MHz clk_sys and a synchronous active-low reset
// Notes on behaviour
// - clock halved into two phases per cycle
// - pc advances phase one, fetch latches phase two
// - flow change takes two cycles, prefetch flushed
// - pc eleven bits, program store 2K x 14
// - pc increments by one otherwise
// - reset loads 000h, interrupt loads 001h
// - jumps load full 11-bit target
// - returns restore pc from stack top
// - writing pc low byte keeps upper bits
// - six-entry return stack, push and pop
// - status bit 4 selects data bank
// - banks to 7Fh, 00h-1Fh shared registers
// - bit operations allowed up to 3Fh
// - indirect port redirects through pointer
// - indirect read with pointer zero gives 00h
// - indirect write to itself does nothing
// - eight-bit alu add, sub, shift, logic
// - accumulator unaddressed, second operand
// - subtract carry means no borrow
// - flag-setting writes to status keep flags
// - zero flag set when result zero
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH
`define RESET_VECTOR 11'h000
`define IRQ_VECTOR 11'h001
`define STACK_DEPTH 6
`define ADDR_INDIRECT 7'h00
`define ADDR_PCL 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_POINTER 7'h04
`define SFR_TOP 7'h1F
`define BIT_TOP 7'h3F
`define ST_C 0
`define ST_NIB 1
`define ST_Z 2
`define ST_BANK 4
`define STATUS_RESET 8'h00
`define STATUS_WMASK 8'h17
`endif

/* File: verilog/core_pkg.sv */
// types shared by the core files
// assumes core_defs.svh supplies the numbers
package core_pkg;
    typedef enum logic [3:0] {
        ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
        ALU_COM, ALU_RL, ALU_RR, ALU_SWAP, ALU_INC, ALU_DEC,
        ALU_BCLR, ALU_BSET
    } alu_op_t;
    typedef enum logic [2:0] {
        FLOW_NEXT, FLOW_JUMP, FLOW_CALL, FLOW_RET, FLOW_SKIP
    } flow_t;
endpackage

/* File: verilog/return_stack.sv */
// six-entry return stack for the program counter
// assumes push and pop never come in the same cycle
`include "core_defs.svh"
module return_stack
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic push,
    input wire logic pop,
    input wire logic [10:0] push_addr,
    output logic [10:0] top_addr
);
    logic [10:0] entry_r [`STACK_DEPTH];
    logic [10:0] entry_nxt [`STACK_DEPTH];

    // ----------------------------------------
    // shift stack: overflow drops the oldest
    // ----------------------------------------
    always_comb
    begin
        for (int i = 0; i < `STACK_DEPTH; i++)
        begin
            if (push && i == 0)
                entry_nxt[i] = push_addr;
            else if (push)
                entry_nxt[i] = entry_r[i - 1];
            else if (pop)
                entry_nxt[i] = (i == `STACK_DEPTH - 1) ? entry_r[i] : entry_r[i + 1];
            else
                entry_nxt[i] = entry_r[i];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `STACK_DEPTH; i++)
                entry_r[i] <= 11'h000;
        end
        else
        begin
            entry_r <= entry_nxt;
        end
    end

    assign top_addr = entry_r[0];
endmodule

/* File: verilog/core_alu.sv */
// eight-bit alu producing result and flags
// assumes operands are stable across the execute phase
`include "core_defs.svh"
module core_alu
    import core_pkg::*;
(
    input wire alu_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    input wire logic [2:0] bit_sel,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_out,
    output logic nib_out,
    output logic zero_out
);
    logic [8:0] wide;
    logic [4:0] low;

    always_comb
    begin
        wide = 9'h000;
        low = 5'h00;
        result = opnd;
        carry_out = carry_in;
        nib_out = 1'b0;
        unique case (op)
            ALU_ADD:
            begin
                wide = {1'b0, opnd} + {1'b0, acc};
                low = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
                result = wide[7:0];
                carry_out = wide[8];
                nib_out = low[4];
            end
            ALU_SUB:
            begin
                wide = {1'b0, opnd} - {1'b0, acc};
                low = {1'b0, opnd[3:0]} - {1'b0, acc[3:0]};
                result = wide[7:0];
                carry_out = ~wide[8];
                nib_out = ~low[4];
            end
            ALU_AND: result = opnd & acc;
            ALU_OR: result = opnd | acc;
            ALU_XOR: result = opnd ^ acc;
            ALU_COM: result = ~opnd;
            ALU_RL:
            begin
                result = {opnd[6:0], carry_in};
                carry_out = opnd[7];
            end
            ALU_RR:
            begin
                result = {carry_in, opnd[7:1]};
                carry_out = opnd[0];
            end
            ALU_SWAP: result = {opnd[3:0], opnd[7:4]};
            ALU_INC: result = opnd + 8'h01;
            ALU_DEC: result = opnd - 8'h01;
            ALU_BCLR: result = opnd & ~(8'h01 << bit_sel);
            ALU_BSET: result = opnd | (8'h01 << bit_sel);
            ALU_PASS: result = opnd;
        endcase
        zero_out = (result == 8'h00);
    end
endmodule

/* File: verif/mem_model.sv */
// program rom and banked data array on the far side of the core
// assumes the bench preloads both arrays through the hierarchy
module mem_model
(
    input wire logic clk_sys,
    input wire logic [10:0] rom_addr,
    input wire logic [7:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic ram_we,
    output logic [13:0] rom_data,
    output logic [7:0] ram_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [13:0] rom [0:2047];
    logic [7:0] ram [0:255];
    assign rom_data = rom[rom_addr];
    // read is combinational, so a write is seen straight after the edge that stores it
    assign ram_rdata = ram[ram_addr];
    always @(posedge clk_sys)
    begin
        if (ram_we)
        begin
            ram[ram_addr] <= ram_wdata;
        end
    end
endmodule

/* File: verif/cpu_core_chk.sv */
// assertions on the core ports: phases, fetch, flush, reset vector, flags
// assumes the decoder inputs follow the hand-over contract
`include "core_defs.svh"
module cpu_core_chk
    import core_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [13:0] rom_data,
    input wire logic [7:0] ram_rdata,
    input wire logic irq_take,
    input wire flow_t flow,
    input wire logic skip_cond,
    input wire alu_op_t alu_op,
    input wire logic use_literal,
    input wire logic [6:0] file_addr,
    input wire logic [2:0] bit_sel,
    input wire logic dest_file,
    input wire logic dest_acc,
    input wire logic flags_cz,
    input wire logic flags_z,
    input wire logic flags_c,
    input wire logic load_literal_acc,
    input wire logic [10:0] rom_addr,
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    input wire logic [7:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic ram_we,
    input wire logic [7:0] acc_out,
    input wire logic [7:0] status_out,
    input wire logic [7:0] pointer_out,
    input wire logic phase_two,
    input wire logic bit_ok
);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    logic flow_chg;
    assign flow_chg = phase_two && instr_valid && !irq_take
        && (flow == FLOW_JUMP || flow == FLOW_CALL || flow == FLOW_RET);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence exec_s;
        phase_two && instr_valid;
    endsequence
    sequence flushed_s;
        !instr_valid [*2] ##1 instr_valid;
    endsequence
    property jump_p;
        logic [10:0] t;
        (flow_chg && flow != FLOW_RET, t = instr[10:0]) |-> ##2 rom_addr == t;
    endproperty
    phase_alt_a: assert property ($past(rst_n) |-> phase_two != $past(phase_two))
        else $error("phase did not alternate");
    pc_hold_a: assert property ($past(rst_n) && !phase_two |-> $stable(rom_addr))
        else $error("fetch address moved outside phase one");
    instr_hold_a: assert property ($past(rst_n) && phase_two |-> $stable(instr))
        else $error("instruction latched outside phase two");
    flush_slot_a: assert property (flow_chg |=> flushed_s)
        else $error("prefetched slot not flushed");
    jump_target_a: assert property (jump_p)
        else $error("jump target not fetched");
    reset_vec_a: assert property (!$past(rst_n) |-> rom_addr == `RESET_VECTOR
        && !phase_two && !instr_valid)
        else $error("reset vector not loaded");
    write_gpr_a: assert property (ram_we |-> ram_addr[6:0] > `SFR_TOP)
        else $error("array written in register area");
    zero_flag_a: assert property (exec_s ##0 (flags_z && dest_acc && !dest_file)
        |=> status_out[`ST_Z] == (acc_out == 8'h00))
        else $error("zero flag wrong");
    status_rsvd_a: assert property (status_out[7:5] == 3'h0 && !status_out[3])
        else $error("unused status bits set");
    acc_exec_a: assert property ($past(rst_n) && $changed(acc_out) |-> !phase_two)
        else $error("accumulator changed outside execute edge");
endmodule
bind cpu_core cpu_core_chk cpu_core_chk_inst (.*);

/* File: verif/cpu_fetch_addressing_status_bench.sv */
// self-checking bench: core with rom and data model, table rows 0-11, then flow cases, then rows 12-22
// assumes the bench plays the decoder, driving one slot per instruction
`include "core_defs.svh"
module cpu_fetch_addressing_status_bench
    import core_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, irq_take, skip_cond, use_literal, dest_file, dest_acc;
    logic flags_cz, flags_z, flags_c, load_literal_acc, instr_valid, ram_we, phase_two, bit_ok;
    logic [13:0] rom_data, instr;
    logic [7:0] ram_rdata, ram_addr, ram_wdata, acc_out, status_out, pointer_out;
    logic [10:0] rom_addr;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    flow_t flow;
    alu_op_t alu_op;
    int mismatches, checked, gap;
    typedef struct packed {
        alu_op_t op;
        logic ul;
        logic [6:0] fa;
        logic [2:0] bs;
        logic [7:0] lit;
        logic [4:0] ctl;
        logic [7:0] acc;
        logic [7:0] st;
        logic [7:0] ptr;
    } row_t;
    // ctl is {to acc, to file, carry and nibble, zero, carry only}
    row_t rows [23] = '{
        '{ALU_PASS, 1'h1, 7'h20, 3'h0, 8'h3C, 5'h10, 8'h3C, 8'h00, 8'h00},
        '{ALU_ADD, 1'h1, 7'h20, 3'h0, 8'h0F, 5'h16, 8'h4B, 8'h02, 8'h00},
        '{ALU_ADD, 1'h1, 7'h20, 3'h0, 8'hB5, 5'h16, 8'h00, 8'h07, 8'h00},
        '{ALU_PASS, 1'h1, 7'h20, 3'h0, 8'h1A, 5'h10, 8'h1A, 8'h07, 8'h00},
        '{ALU_SUB, 1'h1, 7'h20, 3'h0, 8'h2B, 5'h16, 8'h11, 8'h03, 8'h00},
        '{ALU_SUB, 1'h1, 7'h20, 3'h0, 8'h20, 5'h16, 8'h0F, 8'h01, 8'h00},
        '{ALU_SUB, 1'h1, 7'h20, 3'h0, 8'h0F, 5'h16, 8'h00, 8'h07, 8'h00},
        '{ALU_PASS, 1'h1, 7'h20, 3'h0, 8'hA5, 5'h10, 8'hA5, 8'h07, 8'h00},
        '{ALU_AND, 1'h1, 7'h20, 3'h0, 8'h0F, 5'h12, 8'h05, 8'h03, 8'h00},
        '{ALU_XOR, 1'h1, 7'h20, 3'h0, 8'h05, 5'h12, 8'h00, 8'h07, 8'h00},
        '{ALU_OR, 1'h1, 7'h20, 3'h0, 8'hF0, 5'h12, 8'hF0, 8'h03, 8'h00},
        '{ALU_RL, 1'h1, 7'h20, 3'h0, 8'h81, 5'h11, 8'h03, 8'h03, 8'h00},
        '{ALU_PASS, 1'h1, 7'h04, 3'h0, 8'h00, 5'h08, 8'h03, 8'h03, 8'h00},
        '{ALU_PASS, 1'h0, 7'h00, 3'h0, 8'h00, 5'h10, 8'h00, 8'h03, 8'h00},
        '{ALU_PASS, 1'h1, 7'h00, 3'h0, 8'h55, 5'h08, 8'h00, 8'h03, 8'h00},
        '{ALU_PASS, 1'h1, 7'h04, 3'h0, 8'hA5, 5'h08, 8'h00, 8'h03, 8'hA5},
        '{ALU_PASS, 1'h1, 7'h00, 3'h0, 8'h5A, 5'h08, 8'h00, 8'h03, 8'hA5},
        '{ALU_ADD, 1'h1, 7'h03, 3'h0, 8'h0F, 5'h0E, 8'h00, 8'h00, 8'hA5},
        '{ALU_PASS, 1'h0, 7'h00, 3'h0, 8'h00, 5'h10, 8'h5A, 8'h00, 8'hA5},
        '{ALU_BSET, 1'h0, 7'h03, 3'h4, 8'h00, 5'h08, 8'h5A, 8'h10, 8'hA5},
        '{ALU_PASS, 1'h1, 7'h30, 3'h0, 8'h77, 5'h08, 8'h5A, 8'h10, 8'hA5},
        '{ALU_PASS, 1'h1, 7'h40, 3'h0, 8'h66, 5'h08, 8'h5A, 8'h10, 8'hA5},
        '{ALU_BCLR, 1'h0, 7'h03, 3'h4, 8'h00, 5'h08, 8'h5A, 8'h00, 8'hA5}
    };
    cpu_core cpu_core_inst (.*);
    mem_model mem_model_inst (.*);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [10:0] at(input int k);
        return (k < 12) ? 11'(k) : 11'(k + 32'h145);
    endfunction
    // stops in phase one ahead of a valid slot, so the registered data address
    // is already set up when the slot executes; gap counts flushed slots
    task automatic next_slot();
        gap = 0;
        for (int n = 0; n < 40; n++)
        begin
            if (phase_two === 1'b0 && instr_valid === 1'b1)
                return;
            if (phase_two === 1'b1)
                gap++;
            @(posedge clk_sys);
            #1;
        end
        check("slot", 14'h0, 14'h1);
    endtask
    task automatic run(input alu_op_t op, input logic ul, input logic [6:0] fa,
        input logic [2:0] bs, input logic [4:0] ctl, input flow_t fl);
        alu_op = op;
        flow = fl;
        {use_literal, file_addr, bit_sel} = {ul, fa, bs};
        {dest_acc, dest_file, flags_cz, flags_z, flags_c} = ctl;
        @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
        {dest_acc, dest_file, flags_cz, flags_z, flags_c} = 5'h00;
        flow = FLOW_NEXT;
    endtask
    task automatic step(input int k);
        check("instr", instr, mem_model_inst.rom[at(k)]);
        run(rows[k].op, rows[k].ul, rows[k].fa, rows[k].bs, rows[k].ctl, FLOW_NEXT);
        check("acc", acc_out, rows[k].acc);
        check("status", status_out, rows[k].st);
        check("pointer", pointer_out, rows[k].ptr);
        check("bit_ok", bit_ok, rows[k].fa <= `BIT_TOP);
        next_slot();
    endtask
    task automatic hop(input flow_t fl, input logic [10:0] dst, input logic [4:0] ctl);
        run(ALU_PASS, 1'b1, `ADDR_PCL, 3'h0, ctl, fl);
        next_slot();
        check("flushed", gap, 14'h1);
        check("target", instr, mem_model_inst.rom[dst]);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (16) @(posedge clk_sys);
        #1;
        check("rom_addr", rom_addr, `RESET_VECTOR);
        check("acc", acc_out, 8'h00);
        check("status", status_out, `STATUS_RESET);
        check("phase", phase_two, 1'b0);
        rst_n = 1'b1;
        next_slot();
    endtask
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // the whole run needs about 115 cycles; this allows 2000, over fifteen times that
    initial
    begin
        #20000;
        check("watchdog", 14'h0, 14'h1);
        test_done();
    end
    initial
    begin
        {rst_n, irq_take, skip_cond, use_literal, dest_file, dest_acc} = 6'h00;
        {flags_cz, flags_z, flags_c, load_literal_acc} = 4'h0;
        {file_addr, bit_sel} = 10'h000;
        flow = FLOW_NEXT;
        alu_op = ALU_PASS;
        mismatches = 0;
        checked = 0;
        for (int a = 0; a < 2048; a++)
            mem_model_inst.rom[a] = {3'h0, 11'(a)};
        for (int a = 0; a < 256; a++)
            mem_model_inst.ram[a] = ~8'(a);
        foreach (rows[k])
            mem_model_inst.rom[at(k)] = {6'h3F, rows[k].lit};
        mem_model_inst.rom[12] = {3'h7, 11'h140};
        mem_model_inst.rom[11'h140] = {3'h4, 11'h300};
        mem_model_inst.rom[11'h300] = {3'h4, 11'h3A0};
        mem_model_inst.rom[11'h141] = {3'h0, 11'h150};
        do_reset();
        for (int k = 0; k < 12; k++)
            step(k);
        hop(FLOW_JUMP, 11'h140, 5'h00);
        hop(FLOW_CALL, 11'h300, 5'h00);
        hop(FLOW_CALL, 11'h3A0, 5'h00);
        hop(FLOW_RET, 11'h301, 5'h00);
        hop(FLOW_RET, 11'h141, 5'h00);
        hop(FLOW_NEXT, 11'h150, 5'h08);
        irq_take = 1'b1;
        run(ALU_PASS, 1'b1, 7'h20, 3'h0, 5'h00, FLOW_NEXT);
        irq_take = 1'b0;
        next_slot();
        check("irq_vector", instr, mem_model_inst.rom[`IRQ_VECTOR]);
        hop(FLOW_RET, 11'h151, 5'h00);
        for (int k = 12; k < 23; k++)
            step(k);
        check("ram_ind", mem_model_inst.ram[8'hA5], 8'h5A);
        check("ram_self", mem_model_inst.ram[8'h00], 8'hFF);
        check("ram_bank", mem_model_inst.ram[8'hB0], 8'h77);
        check("ram_gpr", mem_model_inst.ram[8'hC0], 8'h66);
        do_reset();
        check("refetch", instr, mem_model_inst.rom[0]);
        test_done();
    end
endmodule
